// *** pwt_timer.sv ***
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
// Operation
// - Counting clock is system clock divided by 1, 4, 16 or 64.
// - Prescale change acts at once; change it only while stopped.
// - 16-bit up counter advances per prescaled tick while enabled.
// - Writing a count byte replaces it directly; stop counter first.
// - High-byte read latches low byte; next low read returns latch.
// - Output mode, compare above period: output equals polarity constantly.
// - Polarity 0: low below compare, high otherwise; polarity 1 inverts.
// - Output level reverses when count reaches period, new period.
// - Count equal compare sets compare flag; counting continues.
// - Count equal period sets overflow, clears count, restarts or stops.
// - Single mode clears counter enable on period-end events.
// - Filter rejects pulses shorter than 4, 8 or 16 cycles.
// - Filtered input lags synchronised input by selected cycles; edges use it.
// - Capture polarity picks active edge; measures period and pulse.
// - First active edge after enable clears counter and restarts.
// - Opposite edge copies count to compare, sets width flag.
// - Second active edge copies count to period, flags, clears.
// - Capture count at 0xFFFF sets overflow, clears, restart/stop.
// - Flags read 1 pending; write 0 clears, write 1 no effect.
// - Three enables gate requests; period pair inert in output mode.
// - Mode bit 0 capture, 1 output; redefines polarity and registers.
module pwt_timer
  import pwt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [9:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        captureIn,
  output logic             pwmOut,
  output logic             irq
);

  pwt_ctrl_t   ctl;
  pwt_state_t  state;
  pwt_state_t  next_state;
  logic [15:0] cnt;
  logic [15:0] cmp;
  logic [15:0] per;
  logic [15:0] next_cnt;
  logic [15:0] next_cmp;
  logic [15:0] next_per;
  logic        cmpFlag;
  logic        perFlag;
  logic        ovfFlag;
  logic        busAck;
  logic [7:0]  lowLatch;
  logic        latchValid;
  logic [5:0]  preCnt;
  logic        syncA;
  logic        syncB;
  logic        filtered;
  logic        filtPrev;
  logic [4:0]  filtCnt;
  logic        setCmp;
  logic        setPer;
  logic        setOvf;
  logic        stopReq;
  logic        edgeClear;

  // Bus decode
  wire        reqValid  = read | write;
  wire        accept    = reqValid & busAck;
  wire        capture   = reqValid & ~busAck;
  wire [7:0]  wordIdx   = address[9:2];
  wire        hitCntLo  = wordIdx == PWT_IDX_CNT_LO;
  wire        hitCntHi  = wordIdx == PWT_IDX_CNT_HI;
  wire        hitCmpLo  = wordIdx == PWT_IDX_CMP_LO;
  wire        hitCmpHi  = wordIdx == PWT_IDX_CMP_HI;
  wire        hitPerLo  = wordIdx == PWT_IDX_PER_LO;
  wire        hitPerHi  = wordIdx == PWT_IDX_PER_HI;
  wire        hitCtrl   = wordIdx == PWT_IDX_CTRL;
  wire        hitFlags  = wordIdx == PWT_IDX_FLAGS;
  wire        wrByte    = write & accept & byteenable[0];
  wire [7:0]  wd        = writedata[7:0];
  wire        wrCntLo   = wrByte & hitCntLo;
  wire        wrCntHi   = wrByte & hitCntHi;
  wire        wrCmpLo   = wrByte & hitCmpLo;
  wire        wrCmpHi   = wrByte & hitCmpHi;
  wire        wrPerLo   = wrByte & hitPerLo;
  wire        wrPerHi   = wrByte & hitPerHi;
  wire        wrCtrl    = wrByte & hitCtrl;
  wire        wrFlags   = wrByte & hitFlags;
  wire        rdCntHi   = read & capture & hitCntHi;
  wire        rdCntLo   = read & capture & hitCntLo;

  wire [7:0] ctrlByte = {1'b0, ctl.prescaleSelect, ctl.polarityEdgeSelect,
                         ctl.compareWidthIrqEnable, 1'b0, ctl.singleShot,
                         ctl.operatingModeSelect};
  wire [7:0] flagByte = {cmpFlag, perFlag, ovfFlag, ctl.periodIrqEnable,
                         ctl.overflowIrqEnable, ctl.filterWidthSelect,
                         ctl.counterEnable};
  // Unmapped words read as zero and ignore writes
  wire [7:0] rdByte =
    hitCntLo ? (latchValid ? lowLatch : cnt[7:0]) :
    hitCntHi ? cnt[15:8] :
    hitCmpLo ? cmp[7:0]  :
    hitCmpHi ? cmp[15:8] :
    hitPerLo ? per[7:0]  :
    hitPerHi ? per[15:8] :
    hitCtrl  ? ctrlByte  :
    hitFlags ? flagByte  : 8'h00;

  assign waitrequest = reqValid & ~busAck;

  always_ff @(posedge clk) begin
    if (rst) begin
      busAck <= 1'b0;
      readdata <= 32'h0000_0000;
    end else begin
      busAck <= capture;
      if (capture) begin
        readdata <= {24'h00_0000, rdByte};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lowLatch <= 8'h00;
      latchValid <= 1'b0;
    end else if (rdCntHi) begin
      lowLatch <= cnt[7:0];
      latchValid <= 1'b1;
    end else if (rdCntLo) begin
      latchValid <= 1'b0;
    end
  end

  // Prescaler; a compare of >= keeps a shrinking divisor from running away
  wire [5:0] preMax =
    (ctl.prescaleSelect == 2'b00) ? PWT_PSC_MAX0 :
    (ctl.prescaleSelect == 2'b01) ? PWT_PSC_MAX1 :
    (ctl.prescaleSelect == 2'b10) ? PWT_PSC_MAX2 : PWT_PSC_MAX3;
  wire tick = ctl.counterEnable & (preCnt >= preMax);

  always_ff @(posedge clk) begin
    if (rst || !ctl.counterEnable || tick) begin
      preCnt <= 6'h00;
    end else begin
      preCnt <= preCnt + 6'h01;
    end
  end

  // Input path: two-flop synchroniser, then glitch filter
  always_ff @(posedge clk) begin
    if (rst) begin
      syncA <= 1'b0;
      syncB <= 1'b0;
    end else begin
      syncA <= captureIn;
      syncB <= syncA;
    end
  end

  wire [4:0] filtLen =
    (ctl.filterWidthSelect == 2'b01) ? PWT_FILT_LEN1 :
    (ctl.filterWidthSelect == 2'b10) ? PWT_FILT_LEN2 : PWT_FILT_LEN3;
  wire filtOff  = ctl.filterWidthSelect == 2'b00;
  wire filtDone = filtCnt == (filtLen - 5'h01);

  always_ff @(posedge clk) begin
    if (rst) begin
      filtered <= 1'b0;
      filtCnt <= 5'h00;
    end else if (filtOff) begin
      filtered <= syncB;
      filtCnt <= 5'h00;
    end else if (syncB == filtered) begin
      filtCnt <= 5'h00;
    end else if (filtDone) begin
      filtered <= syncB;
      filtCnt <= 5'h00;
    end else begin
      filtCnt <= filtCnt + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      filtPrev <= 1'b0;
    end else begin
      filtPrev <= filtered;
    end
  end

  wire riseEdge = filtered & ~filtPrev;
  wire fallEdge = ~filtered & filtPrev;
  wire actEdge  = ctl.polarityEdgeSelect ? fallEdge : riseEdge;
  wire oppEdge  = ctl.polarityEdgeSelect ? riseEdge : fallEdge;
  wire outMode  = ctl.operatingModeSelect;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_cmp = cmp;
    next_per = per;
    setCmp = 1'b0;
    setPer = 1'b0;
    setOvf = 1'b0;
    stopReq = 1'b0;
    edgeClear = 1'b0;
    if (wrCmpLo) next_cmp[7:0] = wd;
    if (wrCmpHi) next_cmp[15:8] = wd;
    if (wrPerLo) next_per[7:0] = wd;
    if (wrPerHi) next_per[15:8] = wd;
    if (!ctl.counterEnable) begin
      next_state = PWT_ST_IDLE;
    end else if (outMode) begin
      next_state = PWT_ST_RUN;
      if (tick) begin
        if (cnt == cmp) begin
          setCmp = 1'b1;
        end
        if (cnt == per) begin
          next_cnt = PWT_CNT_RESET;
          setOvf = 1'b1;
          stopReq = ctl.singleShot;
        end else begin
          next_cnt = cnt + 16'h0001;
        end
      end
    end else begin
      case (state)
        PWT_ST_IDLE: begin
          next_state = PWT_ST_ARM;
        end
        PWT_ST_ARM: begin
          if (actEdge) begin
            edgeClear = 1'b1;
            next_state = PWT_ST_RUN;
          end
        end
        PWT_ST_RUN: begin
          if (actEdge) begin
            next_per = cnt;
            setPer = 1'b1;
            edgeClear = 1'b1;
            stopReq = ctl.singleShot;
          end else if (oppEdge) begin
            next_cmp = cnt;
            setCmp = 1'b1;
          end
        end
        default: begin
          next_state = PWT_ST_IDLE;
        end
      endcase
      if (edgeClear) begin
        next_cnt = PWT_CNT_RESET;
      end else if (tick) begin
        if (cnt == PWT_CNT_MAX) begin
          next_cnt = PWT_CNT_RESET;
          setOvf = 1'b1;
          stopReq = ctl.singleShot;
        end else begin
          next_cnt = cnt + 16'h0001;
        end
      end
    end
    if (wrCntLo) next_cnt[7:0] = wd;
    if (wrCntHi) next_cnt[15:8] = wd;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= PWT_ST_IDLE;
      cnt <= PWT_CNT_RESET;
      cmp <= PWT_REG_RESET;
      per <= PWT_REG_RESET;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      cmp <= next_cmp;
      per <= next_per;
    end
  end

  // Hardware set wins over a software clear in the same cycle
  wire clrCmp = wrFlags & ~wd[PWT_CR1_CMPF];
  wire clrPer = wrFlags & ~wd[PWT_CR1_PERF];
  wire clrOvf = wrFlags & ~wd[PWT_CR1_OVFF];

  always_ff @(posedge clk) begin
    if (rst) begin
      cmpFlag <= 1'b0;
      perFlag <= 1'b0;
      ovfFlag <= 1'b0;
    end else begin
      cmpFlag <= setCmp | (cmpFlag & ~clrCmp);
      perFlag <= setPer | (perFlag & ~clrPer);
      ovfFlag <= setOvf | (ovfFlag & ~clrOvf);
    end
  end

  // A single-shot stop beats a simultaneous write of the enable bit
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl <= PWT_CTRL_RESET;
    end else begin
      if (wrCtrl) begin
        ctl.prescaleSelect <= wd[PWT_CR0_PSC_LSB +: 2];
        ctl.polarityEdgeSelect <= wd[PWT_CR0_POL];
        ctl.compareWidthIrqEnable <= wd[PWT_CR0_CMPIE];
        ctl.singleShot <= wd[PWT_CR0_SINGLE];
        ctl.operatingModeSelect <= wd[PWT_CR0_MODE];
      end
      if (wrFlags) begin
        ctl.periodIrqEnable <= wd[PWT_CR1_PERIE];
        ctl.overflowIrqEnable <= wd[PWT_CR1_OVFIE];
        ctl.filterWidthSelect <= wd[PWT_CR1_FILT_LSB +: 2];
        ctl.counterEnable <= wd[PWT_CR1_CEN];
      end
      if (stopReq) begin
        ctl.counterEnable <= 1'b0;
      end
    end
  end

  // PWM level; the wrap to zero at period end gives the reversal
  wire cmpAbovePer = cmp > per;
  wire belowCmp    = cnt < cmp;
  wire pwmLevel    = cmpAbovePer ? ctl.polarityEdgeSelect :
                     (belowCmp ? ctl.polarityEdgeSelect :
                                 ~ctl.polarityEdgeSelect);

  always_ff @(posedge clk) begin
    if (rst) begin
      pwmOut <= 1'b0;
    end else begin
      pwmOut <= outMode & pwmLevel;
    end
  end

  assign irq = (cmpFlag & ctl.compareWidthIrqEnable)
             | (perFlag & ctl.periodIrqEnable & ~outMode)
             | (ovfFlag & ctl.overflowIrqEnable);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_irq_gate;
    (cmpFlag && ctl.compareWidthIrqEnable)
      || (ovfFlag && ctl.overflowIrqEnable) |-> irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("no irq");
  property p_out_wrap;
    outMode && tick && cnt == per && !wrCntLo && !wrCntHi
      |=> cnt == 16'h0000 && ovfFlag;
  endproperty
  a_out_wrap: assert property (p_out_wrap) else $error("wrap");
  property p_single_stop;
    stopReq |=> !ctl.counterEnable;
  endproperty
  a_single_stop: assert property (p_single_stop)
    else $error("no stop");
  property p_count_up;
    outMode && tick && cnt != per && !wrCntLo && !wrCntHi
      |=> cnt == $past(cnt) + 16'h0001;
  endproperty
  a_count_up: assert property (p_count_up) else $error("no step");
  property p_hold;
    !ctl.counterEnable && !wrCntLo && !wrCntHi |=> $stable(cnt);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved");
  property p_latch;
    rdCntHi |=> latchValid && lowLatch == $past(cnt[7:0]);
  endproperty
  a_latch: assert property (p_latch) else $error("no latch");
  property p_width;
    !outMode && state == PWT_ST_RUN && ctl.counterEnable && oppEdge && !actEdge
      |=> cmp == $past(cnt) && cmpFlag;
  endproperty
  a_width: assert property (p_width) else $error("no capture");
  property p_const_out;
    outMode && cmpAbovePer |=> pwmOut == $past(ctl.polarityEdgeSelect);
  endproperty
  a_const_out: assert property (p_const_out) else $error("level");
  property p_filter;
    $changed(filtered) |-> $past(filtOff) || $past(filtDone);
  endproperty
  a_filter: assert property (p_filter) else $error("too early");
  property p_bus_ack;
    reqValid && waitrequest |=> !waitrequest;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("bus answer late");

endmodule

// *** pwt_pkg.sv ***
package pwt_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [7:0] PWT_IDX_CNT_LO  = 8'h92;
  localparam logic [7:0] PWT_IDX_CNT_HI  = 8'h93;
  localparam logic [7:0] PWT_IDX_CMP_LO  = 8'h94;
  localparam logic [7:0] PWT_IDX_CMP_HI  = 8'h95;
  localparam logic [7:0] PWT_IDX_PER_LO  = 8'h96;
  localparam logic [7:0] PWT_IDX_PER_HI  = 8'h97;
  localparam logic [7:0] PWT_IDX_CTRL    = 8'h9E;
  localparam logic [7:0] PWT_IDX_FLAGS   = 8'h9F;

  // Control/config byte field positions
  localparam int PWT_CR0_PSC_LSB = 5;
  localparam int PWT_CR0_POL     = 4;
  localparam int PWT_CR0_CMPIE   = 3;
  localparam int PWT_CR0_SINGLE  = 1;
  localparam int PWT_CR0_MODE    = 0;

  // Flags/enables byte field positions
  localparam int PWT_CR1_CMPF    = 7;
  localparam int PWT_CR1_PERF    = 6;
  localparam int PWT_CR1_OVFF    = 5;
  localparam int PWT_CR1_PERIE   = 4;
  localparam int PWT_CR1_OVFIE   = 3;
  localparam int PWT_CR1_FILT_LSB = 1;
  localparam int PWT_CR1_CEN     = 0;

  localparam logic [15:0] PWT_CNT_RESET  = 16'h0000;
  localparam logic [15:0] PWT_REG_RESET  = 16'h0000;
  localparam logic [15:0] PWT_CNT_MAX    = 16'hFFFF;

  // Prescaler terminal counts: divide by 1, 4, 16, 64
  localparam logic [5:0] PWT_PSC_MAX0 = 6'h00;
  localparam logic [5:0] PWT_PSC_MAX1 = 6'h03;
  localparam logic [5:0] PWT_PSC_MAX2 = 6'h0F;
  localparam logic [5:0] PWT_PSC_MAX3 = 6'h3F;

  // Glitch filter lengths in system clock cycles
  localparam logic [4:0] PWT_FILT_LEN1 = 5'h04;
  localparam logic [4:0] PWT_FILT_LEN2 = 5'h08;
  localparam logic [4:0] PWT_FILT_LEN3 = 5'h10;

  typedef struct packed {
    logic [1:0] prescaleSelect;
    logic       polarityEdgeSelect;
    logic       compareWidthIrqEnable;
    logic       singleShot;
    logic       operatingModeSelect;
    logic       periodIrqEnable;
    logic       overflowIrqEnable;
    logic [1:0] filterWidthSelect;
    logic       counterEnable;
  } pwt_ctrl_t;

  localparam pwt_ctrl_t PWT_CTRL_RESET = '0;

  typedef enum logic [1:0] {
    PWT_ST_IDLE = 2'b00,
    PWT_ST_ARM  = 2'b01,
    PWT_ST_RUN  = 2'b11
  } pwt_state_t;

endpackage

// *** pwt_pwm_source.sv ***
`timescale 1ns/1ps
module pwt_pwm_source (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic        invert,
  input  wire logic [15:0] onLen,
  input  wire logic [15:0] offLen,
  input  wire logic [3:0]  pulses,
  output logic             lineOut,
  output logic             busy
);
  logic [15:0] phase;
  logic [3:0]  left;
  logic        active;

  initial begin
    busy = 1'b0;
    active = 1'b0;
    phase = 16'h0000;
    left = 4'h0;
  end

  // A GPIO source always drives; between bursts it rests at the idle level
  always @(posedge clk) begin
    if (!busy) begin
      if (go) begin
        busy <= 1'b1;
        left <= pulses;
        phase <= 16'h0000;
        active <= 1'b1;
      end
    end else if (active) begin
      phase <= (phase == onLen - 16'h0001) ? 16'h0000 : phase + 16'h0001;
      if (phase == onLen - 16'h0001) begin
        active <= 1'b0;
      end
    end else if (phase == offLen - 16'h0001) begin
      phase <= 16'h0000;
      left <= left - 4'h1;
      busy <= (left != 4'h1);
      active <= (left != 4'h1);
    end else begin
      phase <= phase + 16'h0001;
    end
  end

  // Inverted source makes the active phase low
  assign lineOut = active ^ invert;
endmodule

// *** pwt_timer_test.sv ***
`timescale 1ns/1ps
module pwt_timer_test;
  import pwt_pkg::*;
  logic        clk, rst, read, write, waitrequest, pwmOut, irq;
  logic        go, invert, busy, captureIn;
  logic [9:0]  address;
  logic [31:0] writedata, readdata;
  logic [3:0]  byteenable, pulses;
  logic [15:0] onLen, offLen, v;
  logic [7:0]  t;
  logic [7:0]  idxs [8];
  int          errorCnt, checksDone, n;

  pwt_timer DUT (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .captureIn(captureIn), .pwmOut(pwmOut), .irq(irq));

  pwt_pwm_source src (.clk(clk), .go(go), .invert(invert), .onLen(onLen),
    .offLen(offLen), .pulses(pulses), .lineOut(captureIn), .busy(busy));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic giveVerdict();
    if (errorCnt == 0 && checksDone > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, g);
    checksDone++;
    if (g !== e) begin
      errorCnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rng(input string nm, input logic [15:0] lo, hi, g);
    checksDone++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      errorCnt++;
      $display("[ERR] %s expected %h..%h seen %h", nm, lo, hi, g);
    end
  endtask

  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] idx, wd,
                     output logic [7:0] rd);
    int k;
    k = 0;
    @(posedge clk);
    address <= {idx, 2'b00};
    read <= ~wr;
    write <= wr;
    writedata <= {24'h000000, wd};
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    if (k >= 50)
      chk("waitrequest", 16'h0000, {15'h0000, waitrequest});
    rd = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, d);
    logic [7:0] x;
    bus(1'b1, idx, d, x);
  endtask

  task automatic rc(input string nm, input logic [7:0] idx, e);
    bus(1'b0, idx, 8'h00, t);
    chk(nm, {8'h00, e}, {8'h00, t});
  endtask

  // High byte first so the low byte comes from the latch
  task automatic rd16(input logic [7:0] lo);
    bus(1'b0, lo + 8'h01, 8'h00, t);
    v[15:8] = t;
    bus(1'b0, lo, 8'h00, t);
    v[7:0] = t;
  endtask

  task automatic wr16(input logic [7:0] lo, input logic [15:0] d);
    wr(lo, d[7:0]);
    wr(lo + 8'h01, d[15:8]);
  endtask

  task automatic run(input logic [15:0] on, off, input logic [3:0] cnt);
    int k;
    k = 0;
    @(posedge clk);
    onLen <= on;
    offLen <= off;
    pulses <= cnt;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    do begin
      @(negedge clk);
      k++;
    end while (busy && k < 3000);
    repeat (30) @(posedge clk);
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    errorCnt++;
    $display("[ERR] run length expected done seen hang");
    giveVerdict();
  end

  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = '0;
    writedata = '0;
    byteenable = 4'hF;
    go = 1'b0;
    invert = 1'b0;
    onLen = 16'h0001;
    offLen = 16'h0001;
    pulses = 4'h1;
    errorCnt = 0;
    checksDone = 0;
    idxs = '{PWT_IDX_CNT_LO, PWT_IDX_CNT_HI, PWT_IDX_CMP_LO, PWT_IDX_CMP_HI,
             PWT_IDX_PER_LO, PWT_IDX_PER_HI, PWT_IDX_CTRL, PWT_IDX_FLAGS};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (idxs[i]) rc("reset value", idxs[i], 8'h00);
    chk("irq after reset", 16'h0000, {15'h0, irq});
    wr(8'h90, 8'h5A);
    rc("unmapped", 8'h90, 8'h00);
    byteenable <= 4'h0;
    wr(PWT_IDX_CTRL, 8'h7F);
    byteenable <= 4'hF;
    rc("masked write", PWT_IDX_CTRL, 8'h00);
    // Count latch: a later low-byte write must not show through the latch
    wr16(PWT_IDX_CNT_LO, 16'h1234);
    rc("count high", PWT_IDX_CNT_HI, 8'h12);
    wr(PWT_IDX_CNT_LO, 8'h56);
    rc("latched low", PWT_IDX_CNT_LO, 8'h34);
    rc("live low", PWT_IDX_CNT_LO, 8'h56);
    for (int p = 0; p < 2; p++) begin
      wr(PWT_IDX_CTRL, {3'b000, p[0], 4'b0001});
      wr16(PWT_IDX_PER_LO, 16'h0100);
      wr16(PWT_IDX_CMP_LO, 16'h0003);
      wr16(PWT_IDX_CNT_LO, 16'h0001);
      repeat (3) @(posedge clk);
      chk("pwm below compare", {15'h0, p[0]}, {15'h0, pwmOut});
      wr16(PWT_IDX_CNT_LO, 16'h0005);
      repeat (3) @(posedge clk);
      chk("pwm at or above", {15'h0, ~p[0]}, {15'h0, pwmOut});
      wr16(PWT_IDX_CMP_LO, 16'h0009);
      wr16(PWT_IDX_PER_LO, 16'h0008);
      wr16(PWT_IDX_CNT_LO, 16'h0000);
      wr(PWT_IDX_FLAGS, 8'h01);
      n = 0;
      repeat (40) begin
        @(negedge clk);
        if (pwmOut !== p[0]) n++;
      end
      chk("pwm constant", 16'h0000, n[15:0]);
      rc("free-run flags", PWT_IDX_FLAGS, 8'h21);
      // Compare 3, period 8: six of every nine counts at the level opposite the polarity
      wr(PWT_IDX_CMP_LO, 8'h03);
      repeat (4) @(posedge clk);
      n = 0;
      repeat (36) begin
        @(negedge clk);
        if (pwmOut !== p[0]) n++;
      end
      chk("pwm duty per period", 16'd24, n[15:0]);
      wr(PWT_IDX_FLAGS, 8'h00);
    end
    wr(PWT_IDX_CTRL, 8'h0B);
    wr16(PWT_IDX_CMP_LO, 16'h0002);
    wr16(PWT_IDX_PER_LO, 16'h0005);
    wr16(PWT_IDX_CNT_LO, 16'h0000);
    wr(PWT_IDX_FLAGS, 8'h09);
    repeat (30) @(posedge clk);
    rc("single-shot flags", PWT_IDX_FLAGS, 8'hA8);
    rd16(PWT_IDX_CNT_LO);
    chk("count after stop", 16'h0000, v);
    chk("irq pending", 16'h0001, {15'h0, irq});
    wr(PWT_IDX_FLAGS, 8'hE8);
    rc("write one keeps", PWT_IDX_FLAGS, 8'hA8);
    wr(PWT_IDX_FLAGS, 8'h28);
    rc("write zero clears", PWT_IDX_FLAGS, 8'h28);
    chk("irq overflow", 16'h0001, {15'h0, irq});
    wr(PWT_IDX_FLAGS, 8'h08);
    // The flag clears at the accepting edge; look once it has settled
    @(posedge clk);
    chk("irq cleared", 16'h0000, {15'h0, irq});
    for (int c = 0; c < 4; c++) begin
      wr(PWT_IDX_CTRL, {1'b0, c[1:0], 5'b00001});
      wr16(PWT_IDX_PER_LO, 16'hFFFF);
      wr16(PWT_IDX_CMP_LO, 16'hFFFF);
      wr16(PWT_IDX_CNT_LO, 16'h0000);
      wr(PWT_IDX_FLAGS, 8'h01);
      repeat ((64 << (2 * c)) - 3) @(posedge clk);
      wr(PWT_IDX_FLAGS, 8'h00);
      rd16(PWT_IDX_CNT_LO);
      rng("prescaled count", 16'd63, 16'd65, v);
    end
    // Capture: every filter code, both active edges, single shot
    for (int f = 0; f < 4; f++) begin
      invert <= f[0];
      wr(PWT_IDX_CTRL, {3'b000, f[0], 4'b1010});
      wr(PWT_IDX_FLAGS, {5'b00010, f[1:0], 1'b1});
      run(16'd20, 16'd30, 4'h2);
      rc("cap flags", PWT_IDX_FLAGS, {5'b11010, f[1:0], 1'b0});
      chk("irq capture", 16'h0001, {15'h0, irq});
      rd16(PWT_IDX_CMP_LO);
      rng("pulse width", 16'd18, 16'd22, v);
      rd16(PWT_IDX_PER_LO);
      rng("period", 16'd48, 16'd52, v);
      // Output mode with the period flag still pending must not interrupt
      wr(PWT_IDX_CTRL, 8'h01);
      @(posedge clk);
      chk("irq output mode", 16'h0000, {15'h0, irq});
      wr(PWT_IDX_FLAGS, 8'h00);
    end
    invert <= 1'b0;
    for (int f = 1; f < 4; f++) begin
      wr(PWT_IDX_CTRL, 8'h00);
      wr(PWT_IDX_FLAGS, {5'b00000, f[1:0], 1'b1});
      run((16'd2 << f) - 16'd1, 16'd20, 4'h1);
      rc("glitch rejected", PWT_IDX_FLAGS, {5'b0, f[1:0], 1'b1});
      wr(PWT_IDX_FLAGS, 8'h00);
    end
    wr(PWT_IDX_CTRL, 8'h02);
    wr16(PWT_IDX_CNT_LO, 16'hFFF0);
    wr(PWT_IDX_FLAGS, 8'h09);
    repeat (40) @(posedge clk);
    rc("capture overflow", PWT_IDX_FLAGS, 8'h28);
    rd16(PWT_IDX_CNT_LO);
    chk("count after overflow", 16'h0000, v);
    chk("irq overflow", 16'h0001, {15'h0, irq});
    giveVerdict();
  end
endmodule
